// >>> inc/swkc_defines.svh
/*
  Named constants of the stopwatch direct-key control block: clock rates,
  derived tick counts, register indices, bit positions and bus answers.
  Assumes inclusion by its bare name from the package and the design files.
*/
`ifndef SWKC_DEFINES_SVH
`define SWKC_DEFINES_SVH

// System clock and the 1,024 Hz key sampling rate.
`define SWKC_CLK_HZ      200000000
`define SWKC_TICK_HZ     1024
`define SWKC_TICK_DIV    (`SWKC_CLK_HZ / `SWKC_TICK_HZ)

// Shortest release window in microseconds, rounded up to sampling ticks.
`define SWKC_DB_MIN_US   46800
`define SWKC_DB_TICKS    ((`SWKC_DB_MIN_US * `SWKC_TICK_HZ + 999999) / 1000000)

// Register indices; the byte address is four times the index.
`define SWKC_AW          18
`define SWKC_IDX_FOUT    16'hFF06
`define SWKC_IDX_DIKM    16'hFF78
`define SWKC_IDX_STAT    16'hFF79
`define SWKC_IDX_MS      16'hFF7A
`define SWKC_IDX_HUN     16'hFF7B
`define SWKC_IDX_TEN     16'hFF7C
`define SWKC_IDX_IEN     16'hFFE6
`define SWKC_IDX_IFL     16'hFFF6

// Bit positions inside the 4-bit registers.
`define SWKC_BIT_KASSIGN 2
`define SWKC_BIT_DIRECT_INPUT_ENABLE    3
`define SWKC_BIT_LAP_CARRY_REQUEST_FLAG   3
`define SWKC_BIT_CAPTURE_RENEWAL_FLAG   2
`define SWKC_BIT_RUN     1
`define SWKC_BIT_RST     0
`define SWKC_BIT_DIRECT_RUN_FACTOR_FLAG    3
`define SWKC_BIT_DIRECT_LAP_FACTOR_FLAG    2
`define SWKC_BIT_I1HZ    1
`define SWKC_BIT_I10HZ   0

// Reset values, digit limit and bus responses.
`define SWKC_NIB_ZERO    4'h0
`define SWKC_BCD_MAX     4'h9
`define SWKC_RESP_OKAY   2'b00
`define SWKC_RESP_SLVERR 2'b10

`endif

// >>> inc/swkc_pkg.sv
/*
  Types of the stopwatch direct-key control block: bus carriers, register
  selector and key filter states.
  Assumes swkc_defines.svh is on the include path.
*/
`include "swkc_defines.svh"

package swkc_pkg;

  // AXI4-Lite master to slave signals.
  typedef struct packed {
    logic                   awvalid;
    logic [`SWKC_AW-1:0]    awaddr;
    logic                   wvalid;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bready;
    logic                   arvalid;
    logic [`SWKC_AW-1:0]    araddr;
    logic                   rready;
  } swkc_axi_req_s;

  // AXI4-Lite slave to master signals.
  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } swkc_axi_rsp_s;

  // Register selected by a bus address.
  typedef enum logic [3:0] {
    SWKC_R_NONE, SWKC_R_FOUT, SWKC_R_DIKM, SWKC_R_STAT, SWKC_R_MS,
    SWKC_R_HUN, SWKC_R_TEN, SWKC_R_IEN, SWKC_R_IFL
  } swkc_reg_e;

  // Key filter states, Gray coded along idle, held, releasing.
  typedef enum logic [1:0] {
    SWKC_DB_IDLE = 2'b00,
    SWKC_DB_HELD = 2'b01,
    SWKC_DB_REL  = 2'b11
  } swkc_db_e;

endpackage

// >>> design/swkc_key_filter.sv
/*
  Release-judged key filter for one direct key.
  Assumes level is already synchronised and tick is a one-cycle pulse at
  each falling edge of the 1,024 Hz sampling clock.
*/
`timescale 1ns/1ps
`include "swkc_defines.svh"

module swkc_key_filter
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic level,
  output logic      active,
  output logic      press
);
  import swkc_pkg::*;

  typedef struct packed {
    swkc_db_e   st;
    logic [5:0] cnt;
  } swkc_kf_s;

  swkc_kf_s st_reg;
  swkc_kf_s st_next;

  // Bounce is judged only at release, so a press is seen at once.
  always_comb
  begin
    st_next = st_reg;
    if (tick)
    begin
      unique case (st_reg.st)
        SWKC_DB_IDLE:
        begin
          if (level)
            st_next.st = SWKC_DB_HELD;
        end
        SWKC_DB_HELD:
        begin
          if (!level)
          begin
            st_next.st  = SWKC_DB_REL;
            st_next.cnt = 6'h00;
          end
        end
        SWKC_DB_REL:
        begin
          // A bounce inside the window returns to held, no second press.
          if (level)
            st_next.st = SWKC_DB_HELD;
          else if (st_next.cnt == 6'(`SWKC_DB_TICKS - 1))
            st_next.st = SWKC_DB_IDLE;
          else
            st_next.cnt = st_reg.cnt + 6'h01;
        end
        default:
          st_next.st = SWKC_DB_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st_reg <= '{st: SWKC_DB_IDLE, cnt: 6'h00};
    else
      st_reg <= st_next;
  end

  // Internal key signal and its rising edge on the sampling tick.
  assign active = (st_reg.st != SWKC_DB_IDLE);
  assign press  = tick && (st_reg.st == SWKC_DB_IDLE) && level;
endmodule

// >>> design/swkc_bcd_digit.sv
/*
  One 4-bit BCD counter stage of the stopwatch.
  Assumes inc is a one-cycle pulse from the lower stage or the tick.
*/
`timescale 1ns/1ps
`include "swkc_defines.svh"

module swkc_bcd_digit
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       inc,
  output logic [3:0]      digit,
  output logic            wrap
);
  import swkc_pkg::*;

  typedef struct packed {
    logic [3:0] val;
  } swkc_bcd_s;

  swkc_bcd_s st_reg;
  swkc_bcd_s st_next;

  // Carry out when the digit turns from nine to zero.
  assign wrap  = inc && (st_reg.val == `SWKC_BCD_MAX);
  assign digit = st_reg.val;

  // Clear wins over counting so a reset while running restarts at zero.
  always_comb
  begin
    st_next = st_reg;
    if (clear)
      st_next.val = `SWKC_NIB_ZERO;
    else if (wrap)
      st_next.val = `SWKC_NIB_ZERO;
    else if (inc)
      st_next.val = st_reg.val + 4'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st_reg <= '{val: `SWKC_NIB_ZERO};
    else
      st_reg <= st_next;
  end
endmodule

// >>> design/swkc_top.sv
/*
  Stopwatch direct-key control: key sampling, key mask, run toggle, lap
  capture, hold and renewal flags, interrupt factor flags and masks, with
  registers on an AXI4-Lite slave.
  Assumes key pins are asynchronous and read high while a key is pressed,
  and one AXI4-Lite master on the same clock.
*/
// The AXI4-Lite interface to the registers was chosen for this implementation.
// Contract
// - Assign bit 0 gives line 0 RUN and line 1 LAP; 1 swaps them.
// - With direct input on, each accepted RUN press toggles run and stop.
// - Key lines still read as normal port inputs.
// - Key levels are sampled at the 1,024 Hz falling edge.
// - Bounce is judged at release; bounces under about 47 to 62 ms vanish.
// - Run status bit reads the true run state even under direct control.
// - Accepted LAP latches counter digits into the buffer; counting goes on.
// - Lap data stays held until the tenths digit is read.
// - LAP while held overwrites; next tenths read sets renewal and keeps hold.
// - Tenths digit overflow sets the 1 Hz factor flag.
// - Entering hold copies the 1 Hz factor flag into the carry request flag.
// - Three-bit mask select chooses which port lines act as mask keys.
// - RUN or LAP pressed while a mask key is held is ignored.
// - Lone, joint, overlapping, or with-mask-simultaneous presses are accepted.
// - Presses are simultaneous only when first sampled on the same edge.
// - Hundredths and tenths wraps from nine to zero set the 10 and 1 Hz flags.
// - Flags set regardless of masks; only the requests are gated.
// - Direct RUN and LAP flags set on the sampled key's rising edge.
// - Each of the four interrupts has its own enable bit.
// - Reading milliseconds latches all three digits and starts the hold.
// - The direct input enable takes effect at the next sampling edge.
// - Software run writes act only while direct input is disabled.
// - Writing 1 to the reset bit clears counters, not the buffer; reads 0.
`timescale 1ns/1ps
`include "swkc_defines.svh"

module swkc_top
#(
  parameter int TICK_DIV = `SWKC_TICK_DIV
)
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire swkc_pkg::swkc_axi_req_s axi_req,
  output swkc_pkg::swkc_axi_rsp_s    axi_rsp,
  input  wire logic [3:0]            port0_pin,
  input  wire logic [3:0]            port1_pin,
  output logic [3:0]                 port0_level,
  output logic [3:0]                 port1_level,
  output logic [3:0]                 irq_req
);
  import swkc_pkg::*;

  // State of the block in one record, apart from the key filters and digit counters.
  typedef struct packed {
    logic [3:0]  p0_s1;
    logic [3:0]  p0_s2;
    logic [3:0]  p1_s1;
    logic [3:0]  p1_s2;
    logic [17:0] div_cnt;
    logic        tick;
    logic        mask_prev;
    logic [3:0]  fout;
    logic [3:0]  dikm;
    logic        direct_input_enable_eff;
    logic        run;
    logic        run_pend;
    logic        run_val;
    logic        lap_carry_request_flag;
    logic        capture_renewal_flag;
    logic        renewed;
    logic        hold;
    logic [11:0] cap;
    logic [3:0]  ien;
    logic [3:0]  ifl;
    logic [3:0]  irq;
    logic        aw_got;
    logic [`SWKC_AW-1:0] awaddr;
    logic        w_got;
    logic [3:0]  wdata;
    logic        wstrb0;
    swkc_axi_rsp_s rsp;
  } swkc_state_s;

  swkc_state_s st_reg;
  swkc_state_s st_next;

  logic [1:0]  key_lvl;
  logic [1:0]  key_press;
  logic [11:0] digits;
  logic [2:0]  digit_wrap;
  logic [2:0]  digit_inc;
  logic        cnt_clear;

  // Byte address of a register index, cut to the bus address width.
  function automatic logic [`SWKC_AW-1:0] idx_addr(input logic [15:0] idx);
    idx_addr = {idx, 2'b00};
  endfunction

  // Address decode, shared by the read and write paths.
  function automatic swkc_reg_e reg_sel(input logic [`SWKC_AW-1:0] a);
    reg_sel = SWKC_R_NONE;
    if (a == idx_addr(`SWKC_IDX_FOUT))
      reg_sel = SWKC_R_FOUT;
    else if (a == idx_addr(`SWKC_IDX_DIKM))
      reg_sel = SWKC_R_DIKM;
    else if (a == idx_addr(`SWKC_IDX_STAT))
      reg_sel = SWKC_R_STAT;
    else if (a == idx_addr(`SWKC_IDX_MS))
      reg_sel = SWKC_R_MS;
    else if (a == idx_addr(`SWKC_IDX_HUN))
      reg_sel = SWKC_R_HUN;
    else if (a == idx_addr(`SWKC_IDX_TEN))
      reg_sel = SWKC_R_TEN;
    else if (a == idx_addr(`SWKC_IDX_IEN))
      reg_sel = SWKC_R_IEN;
    else if (a == idx_addr(`SWKC_IDX_IFL))
      reg_sel = SWKC_R_IFL;
  endfunction

  // Mask key lines for a select code, as {port1[3:0], port0[3:0]}.
  function automatic logic [7:0] mask_lines(input logic [2:0] sel);
    unique case (sel)
      3'h0: mask_lines = 8'h00;
      3'h1: mask_lines = 8'h04;
      3'h2: mask_lines = 8'h0C;
      3'h3: mask_lines = 8'h1C;
      3'h4: mask_lines = 8'h10;
      3'h5: mask_lines = 8'h30;
      3'h6: mask_lines = 8'h70;
      3'h7: mask_lines = 8'hF0;
    endcase
  endfunction

  // Key roles follow the assign bit; index 0 is RUN and index 1 is LAP.
  assign key_lvl[0] = st_reg.fout[`SWKC_BIT_KASSIGN] ?
                      st_reg.p0_s2[1] : st_reg.p0_s2[0];
  assign key_lvl[1] = st_reg.fout[`SWKC_BIT_KASSIGN] ?
                      st_reg.p0_s2[0] : st_reg.p0_s2[1];

  // One release filter per direct key.
  generate
    for (genvar k = 0; k < 2; k++)
    begin : g_key
      swkc_key_filter u_filt
      (
        .mclk   (mclk),
        .rst    (rst),
        .tick   (st_reg.tick),
        .level  (key_lvl[k]),
        .active (),
        .press  (key_press[k])
      );
    end
  endgenerate

  // Counter chain; prescaler pulse correction is not modelled here.
  assign digit_inc[0] = st_reg.tick && st_reg.run;
  assign digit_inc[1] = digit_wrap[0];
  assign digit_inc[2] = digit_wrap[1];

  generate
    for (genvar d = 0; d < 3; d++)
    begin : g_dig
      swkc_bcd_digit u_dig
      (
        .mclk  (mclk),
        .rst   (rst),
        .clear (cnt_clear),
        .inc   (digit_inc[d]),
        .digit (digits[4*d +: 4]),
        .wrap  (digit_wrap[d])
      );
    end
  endgenerate

  // Write handshake completes when both address and data are in.
  logic        wr_go;
  swkc_reg_e   wr_sel;
  logic        rd_go;
  swkc_reg_e   rd_sel;

  assign wr_go  = st_reg.aw_got && st_reg.w_got && !st_reg.rsp.bvalid;
  assign wr_sel = reg_sel(st_reg.awaddr);
  assign rd_go  = axi_req.arvalid && st_reg.rsp.arready;
  assign rd_sel = reg_sel(axi_req.araddr);
  assign cnt_clear = wr_go && st_reg.wstrb0 && (wr_sel == SWKC_R_STAT) &&
                     st_reg.wdata[`SWKC_BIT_RST];

  // All block behaviour; hardware sets are applied after software clears.
  always_comb
  begin
    logic [7:0] mlines;
    logic       mask_now;
    logic       run_acc;
    logic       lap_acc;
    logic [3:0] rd_val;
    logic [3:0] ev;
    mlines   = mask_lines(st_reg.dikm[2:0]);
    mask_now = 1'b0;
    run_acc  = 1'b0;
    lap_acc  = 1'b0;
    rd_val   = `SWKC_NIB_ZERO;
    ev       = `SWKC_NIB_ZERO;
    st_next  = st_reg;

    // Two-stage synchronisers; the first stage feeds only the second.
    st_next.p0_s1 = port0_pin;
    st_next.p0_s2 = st_reg.p0_s1;
    st_next.p1_s1 = port1_pin;
    st_next.p1_s2 = st_reg.p1_s1;

    // The sampling tick stands for the 1,024 Hz falling edge.
    if (st_reg.div_cnt == 18'(TICK_DIV - 1))
    begin
      st_next.div_cnt = 18'h0_0000;
      st_next.tick    = 1'b1;
    end
    else
    begin
      st_next.div_cnt = st_reg.div_cnt + 18'h0_0001;
      st_next.tick    = 1'b0;
    end

    // Mask state is judged per tick, against the previous tick's sample.
    mask_now = |(mlines & {st_reg.p1_s2, st_reg.p0_s2});
    if (st_reg.tick)
      st_next.mask_prev = mask_now;

    // A press is refused if direct input is off or a mask key was down at the previous tick, not this one.
    run_acc = st_reg.direct_input_enable_eff && key_press[0] && !st_reg.mask_prev;
    lap_acc = st_reg.direct_input_enable_eff && key_press[1] && !st_reg.mask_prev;

    // Enable switch and software run request act on the sampling edge.
    if (st_reg.tick)
    begin
      st_next.direct_input_enable_eff = st_reg.dikm[`SWKC_BIT_DIRECT_INPUT_ENABLE];
      if (st_reg.run_pend)
      begin
        st_next.run_pend = 1'b0;
        if (!st_reg.direct_input_enable_eff)
          st_next.run = st_reg.run_val;
      end
    end
    if (run_acc)
      st_next.run = !st_reg.run;

    // Bus write channel; address and data may arrive in either order.
    if (axi_req.awvalid && st_reg.rsp.awready)
    begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_reg.rsp.wready)
    begin
      st_next.w_got  = 1'b1;
      st_next.wdata  = axi_req.wdata[3:0];
      st_next.wstrb0 = axi_req.wstrb[0];
    end
    if (wr_go)
    begin
      st_next.aw_got    = 1'b0;
      st_next.w_got     = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp  = (wr_sel == SWKC_R_NONE) ?
                           `SWKC_RESP_SLVERR : `SWKC_RESP_OKAY;
      if (st_reg.wstrb0)
      begin
        unique case (wr_sel)
          SWKC_R_FOUT: st_next.fout = st_reg.wdata;
          SWKC_R_DIKM: st_next.dikm = st_reg.wdata;
          SWKC_R_STAT:
          begin
            // The request waits for the tick; an enabled direct input then drops it.
            st_next.run_pend = 1'b1;
            st_next.run_val  = st_reg.wdata[`SWKC_BIT_RUN];
          end
          SWKC_R_IEN: st_next.ien = st_reg.wdata;
          SWKC_R_IFL: st_next.ifl = st_reg.ifl & ~st_reg.wdata;
          default: st_next.ifl = st_reg.ifl;
        endcase
      end
    end
    else if (st_reg.rsp.bvalid && axi_req.bready)
      st_next.rsp.bvalid = 1'b0;

    // Bus read channel; read side effects act on the taken request.
    if (rd_go)
    begin
      unique case (rd_sel)
        SWKC_R_FOUT: rd_val = st_reg.fout;
        SWKC_R_DIKM: rd_val = st_reg.dikm;
        SWKC_R_STAT: rd_val = {st_reg.lap_carry_request_flag, st_reg.capture_renewal_flag, st_reg.run, 1'b0};
        SWKC_R_MS:
        begin
          // All three digits are frozen together by this read.
          rd_val           = digits[3:0];
          st_next.cap      = digits;
          st_next.hold     = 1'b1;
          st_next.renewed  = 1'b0;
          st_next.lap_carry_request_flag    = st_reg.ifl[`SWKC_BIT_I1HZ];
        end
        SWKC_R_HUN: rd_val = st_reg.hold ? st_reg.cap[7:4] : digits[7:4];
        SWKC_R_TEN:
        begin
          rd_val        = st_reg.hold ? st_reg.cap[11:8] : digits[11:8];
          st_next.capture_renewal_flag = st_reg.renewed;
          if (st_reg.renewed)
            st_next.renewed = 1'b0;
          else
            st_next.hold = 1'b0;
        end
        SWKC_R_IEN: rd_val = st_reg.ien;
        SWKC_R_IFL: rd_val = st_reg.ifl;
        default: rd_val = `SWKC_NIB_ZERO;
      endcase
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rdata  = {28'h000_0000, rd_val};
      st_next.rsp.rresp  = (rd_sel == SWKC_R_NONE) ?
                           `SWKC_RESP_SLVERR : `SWKC_RESP_OKAY;
    end
    else if (st_reg.rsp.rvalid && axi_req.rready)
      st_next.rsp.rvalid = 1'b0;

    // A lap press freezes the digits while the counters run on.
    if (lap_acc)
    begin
      st_next.cap   = digits;
      st_next.hold  = 1'b1;
      st_next.lap_carry_request_flag = st_reg.ifl[`SWKC_BIT_I1HZ];
      if (st_reg.hold)
        st_next.renewed = 1'b1;
    end

    // Hardware events set the flags whatever the masks, and win over clears.
    ev[`SWKC_BIT_DIRECT_RUN_FACTOR_FLAG]  = run_acc;
    ev[`SWKC_BIT_DIRECT_LAP_FACTOR_FLAG]  = lap_acc;
    ev[`SWKC_BIT_I1HZ]  = digit_wrap[2];
    ev[`SWKC_BIT_I10HZ] = digit_wrap[1];
    st_next.ifl = st_next.ifl | ev;

    // Requests to the processor are gated by the enables only.
    st_next.irq = st_next.ifl & st_next.ien;

    // Ready outputs are registered from the next state.
    st_next.rsp.awready = !st_next.aw_got && !st_next.rsp.bvalid;
    st_next.rsp.wready  = !st_next.w_got && !st_next.rsp.bvalid;
    st_next.rsp.arready = !st_next.rsp.rvalid;
  end

  // Single register stage for the state record; reset values are constants.
  always_ff @(posedge mclk)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Key lines stay ordinary input port bits after synchronisation.
  assign port0_level = st_reg.p0_s2;
  assign port1_level = st_reg.p1_s2;
  assign irq_req     = st_reg.irq;
  assign axi_rsp     = st_reg.rsp;
endmodule

// >>> testbench/swkc_props.sv
/*
  Port checker of the stopwatch key block, bound into its top module.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module swkc_props
#(
  parameter int TICK_DIV = 8
)
(
  input wire logic                    mclk,
  input wire logic                    rst,
  input wire swkc_pkg::swkc_axi_req_s axi_req,
  input wire swkc_pkg::swkc_axi_rsp_s axi_rsp,
  input wire logic [3:0]              port0_pin,
  input wire logic [3:0]              port1_pin,
  input wire logic [3:0]              port0_level,
  input wire logic [3:0]              port1_level,
  input wire logic [3:0]              irq_req
);
  import swkc_pkg::*;
  localparam int KEY_LAT = TICK_DIV + 8;
  logic [7:0] since;
  logic [7:0] key_age;
  logic [7:0] wr_age;

  // Ages since reset, a key line and a data write; an enable write alone may raise a request.
  always_ff @(posedge mclk)
  begin
    since   <= rst ? 8'h00 : since + {7'h00, since < 8'h04};
    key_age <= rst ? 8'hFF : |port0_pin[1:0] ? 8'h00 : key_age + {7'h00, key_age < 8'hFF};
    wr_age  <= rst ? 8'hFF : axi_req.wvalid && axi_rsp.wready ? 8'h00 :
               wr_age + {7'h00, wr_age < 8'hFF};
  end

  function automatic logic mapped(input logic [17:0] a);
    return a inside {18'h3_FC18, 18'h3_FDE0, 18'h3_FDE4, 18'h3_FDE8, 18'h3_FDEC,
                     18'h3_FDF0, 18'h3_FF98, 18'h3_FFD8};
  endfunction

  sequence s_wr_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence

  sequence s_rd_taken;
    axi_req.arvalid && axi_rsp.arready;
  endsequence

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  chk_level_pass:
    assert property (since == 8'h04 |->
      {port1_level, port0_level} == $past({port1_pin, port0_pin}, 2))
    else $error("port level is not the pin two cycles back");
  chk_wr_answer:
    assert property (s_wr_taken |-> ##[1:2] axi_rsp.bvalid)
    else $error("write response late");
  chk_wr_unmapped:
    assert property (s_wr_taken ##0 !mapped(axi_req.awaddr) |-> ##[1:2]
      (axi_rsp.bvalid && axi_rsp.bresp == 2'b10))
    else $error("unmapped write not refused");
  chk_rd_answer:
    assert property (s_rd_taken |=> axi_rsp.rvalid)
    else $error("read response late");
  chk_rd_unmapped:
    assert property (s_rd_taken ##0 !mapped(axi_req.araddr) |=>
      axi_rsp.rresp == 2'b10 && axi_rsp.rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_rd_upper:
    assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:4] == 28'h000_0000)
    else $error("upper read bits not zero");
  chk_irq_reset:
    assert property ($fell(rst) |-> irq_req == 4'h0 && !axi_rsp.bvalid && !axi_rsp.rvalid)
    else $error("outputs busy after reset");
  chk_run_cause:
    assert property ($rose(irq_req[3]) |-> key_age < KEY_LAT || wr_age < 8'h08)
    else $error("run request without key");
  chk_lap_cause:
    assert property ($rose(irq_req[2]) |-> key_age < KEY_LAT || wr_age < 8'h08)
    else $error("lap request without key");
endmodule

bind swkc_top swkc_props #(.TICK_DIV(TICK_DIV)) swkc_props_inst (.mclk(mclk), .rst(rst),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .port0_pin(port0_pin), .port1_pin(port1_pin),
  .port0_level(port0_level), .port1_level(port1_level), .irq_req(irq_req));

// >>> testbench/swkc_keys.sv
/*
  Push-key model: a pressed key pulls its line high, a free line reads low.
  Assumes the bench sets wanted levels and chatter lines after a clock edge.
*/
`timescale 1ns/1ps
module swkc_keys
(
  input  wire logic       mclk,
  input  wire logic [7:0] want,
  input  wire logic [1:0] chatter,
  output logic [3:0]      port0_pin = 4'h0,
  output logic [3:0]      port1_pin = 4'h0
);
  logic [7:0] lfsr_reg = 8'hA5;

  // Bounce is pseudo-random per cycle so the sampled level is never a fixed guess.
  always @(posedge mclk)
  begin
    lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    {port1_pin, port0_pin} <= want | {6'h00, chatter & {2{lfsr_reg[0]}}};
  end
endmodule

// >>> testbench/swkc_top_tb.sv
/*
  Self-checking bench of the stopwatch key block with the push-key model.
  Assumes the block's package and header are on the include path.
*/
`timescale 1ns/1ps
`include "swkc_defines.svh"
module swkc_top_tb;
  import swkc_pkg::*;
  localparam int T = 8;
  logic          mclk = 1'b0;
  logic          rst = 1'b1;
  logic [1:0]    chatter = 2'b00;
  logic [7:0]    want = 8'h00;
  logic [3:0]    p0, p1, l0, l1, irq;
  swkc_axi_req_s q = '0;
  swkc_axi_rsp_s r;
  logic [31:0]   d;
  logic [1:0]    resp;
  logic [15:0]   regs [8] = '{`SWKC_IDX_FOUT, `SWKC_IDX_DIKM, `SWKC_IDX_STAT, `SWKC_IDX_MS,
                              `SWKC_IDX_HUN, `SWKC_IDX_TEN, `SWKC_IDX_IEN, `SWKC_IDX_IFL};
  int            mismatches = 0;
  int            checked = 0;

  swkc_top #(.TICK_DIV(T)) swkc_top_inst (.mclk(mclk), .rst(rst), .axi_req(q), .axi_rsp(r),
    .port0_pin(p0), .port1_pin(p1), .port0_level(l0), .port1_level(l1), .irq_req(irq));
  swkc_keys swkc_keys_inst (.mclk(mclk), .want(want), .chatter(chatter), .port0_pin(p0),
    .port1_pin(p1));

  // Clock of 5 ns period.
  initial forever #2.5 mclk = ~mclk;

  task automatic tally_and_finish();
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n * T) @(posedge mclk);
  endtask

  // Address and data go out together; both are held until both readies are seen together.
  task automatic wr(input logic [15:0] i, input logic [3:0] v);
    @(posedge mclk);
    q.awvalid <= 1'b1;
    q.awaddr  <= {i, 2'b00};
    q.wvalid  <= 1'b1;
    q.wdata   <= {28'h000_0000, v};
    q.wstrb   <= 4'hF;
    q.bready  <= 1'b1;
    do @(posedge mclk); while (!(r.awready && r.wready));
    q.awvalid <= 1'b0;
    q.wvalid  <= 1'b0;
    do @(posedge mclk); while (!r.bvalid);
    q.bready <= 1'b0;
    resp = r.bresp;
  endtask

  task automatic rd(input logic [15:0] i);
    @(posedge mclk);
    q.arvalid <= 1'b1;
    q.araddr  <= {i, 2'b00};
    q.rready  <= 1'b1;
    do @(posedge mclk); while (!r.arready);
    q.arvalid <= 1'b0;
    do @(posedge mclk); while (!r.rvalid);
    q.rready <= 1'b0;
    d = r.rdata;
    resp = r.rresp;
  endtask

  // Expected status nibble: carry request, renewal, run, and a reset bit that reads 0.
  function automatic logic [3:0] stat_exp(input logic lc, input logic rn, input logic run);
    return {lc, rn, run, 1'b0};
  endfunction

  task automatic rc(input logic [15:0] i, input logic [3:0] e);
    rd(i);
    chk(d[3:0], e);
  endtask

  // Holds base keys first, then presses k, releases it with chatter and waits out the window.
  task automatic press(input logic [7:0] k, input logic [7:0] base);
    @(posedge mclk);
    want <= base;
    ticks(2);
    want <= base | k;
    ticks(4 + $urandom_range(12));
    want    <= base;
    chatter <= k[1:0];
    ticks(2 + $urandom_range(20));
    chatter <= 2'b00;
    ticks(60);
    want <= 8'h00;
  endtask

  // Hang guard, well beyond the expected run of about 21,000 cycles.
  initial
  begin
    #400000;
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    logic [3:0] h;
    void'($urandom(48));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    // Reset values, a random read-back and both error answers.
    foreach (regs[n])
    begin
      rd(regs[n]);
      chk(d[3:0] | {2'b00, resp}, 4'h0);
    end
    h = 4'($urandom);
    wr(`SWKC_IDX_FOUT, h);
    rc(`SWKC_IDX_FOUT, h);
    rd(16'hFF7D);
    chk({2'b00, resp}, 4'h2);
    wr(16'hFF7D, 4'hF);
    chk({2'b00, resp}, 4'h2);
    // Software run for just over one second, then each enable alone.
    wr(`SWKC_IDX_STAT, 4'h2);
    ticks(1010);
    rc(`SWKC_IDX_IFL, 4'h3);
    chk(irq, 4'h0);
    for (int e = 0; e < 4; e++)
    begin
      wr(`SWKC_IDX_IEN, 4'h1 << e);
      repeat (3) @(posedge mclk);
      chk(irq, (4'h1 << e) & 4'h3);
    end
    // A millisecond read holds the digits while the count goes on.
    rd(`SWKC_IDX_MS);
    rc(`SWKC_IDX_STAT, stat_exp(1'b1, 1'b0, 1'b1));
    rd(`SWKC_IDX_HUN);
    h = d[3:0];
    ticks(30);
    rc(`SWKC_IDX_HUN, h);
    rd(`SWKC_IDX_TEN);
    wr(`SWKC_IDX_STAT, 4'h3);
    rc(`SWKC_IDX_TEN, 4'h0);
    wr(`SWKC_IDX_STAT, 4'h0);
    wr(`SWKC_IDX_IEN, 4'hC);
    // Port interrupts of lines 0 and 1 sit outside this block and stay off.
    wr(`SWKC_IDX_DIKM, 4'h8);
    // Direct keys under both assignments: two run toggles around a renewed lap.
    for (int a = 0; a < 2; a++)
    begin
      wr(`SWKC_IDX_FOUT, {1'b0, a[0], 2'b00});
      wr(`SWKC_IDX_STAT, 4'h2);
      ticks(2);
      rd(`SWKC_IDX_STAT);
      chk({3'b000, d[1]}, 4'h0);
      for (int k = 0; k < 2; k++)
      begin
        wr(`SWKC_IDX_IFL, 4'hF);
        press(a ? 8'h02 : 8'h01, 8'h00);
        rd(`SWKC_IDX_STAT);
        chk({3'b000, d[1]}, 4'(1 - k));
        chk(irq, 4'h8);
        if (k == 0)
        begin
          press(a ? 8'h01 : 8'h02, 8'h00);
          chk(irq, 4'hC);
          rd(`SWKC_IDX_HUN);
          h = d[3:0];
          ticks(30);
          rc(`SWKC_IDX_HUN, h);
          press(a ? 8'h01 : 8'h02, 8'h00);
          rd(`SWKC_IDX_TEN);
          rc(`SWKC_IDX_STAT, stat_exp(1'b0, 1'b1, 1'b1));
          rd(`SWKC_IDX_TEN);
          rc(`SWKC_IDX_STAT, stat_exp(1'b0, 1'b0, 1'b1));
        end
      end
    end
    // Each mask code with its last key held ahead of the run key.
    wr(`SWKC_IDX_FOUT, 4'h0);
    for (int s = 0; s < 8; s++)
    begin
      wr(`SWKC_IDX_DIKM, {1'b1, 3'(s)});
      wr(`SWKC_IDX_IFL, 4'hF);
      press(8'h01, 8'h01 << (s < 2 ? 2 : s < 4 ? s + 1 : s));
      rd(`SWKC_IDX_IFL);
      chk({3'b000, d[3]}, {3'b000, s == 0});
    end
    wr(`SWKC_IDX_IFL, 4'hF);
    press(8'h83, 8'h00);
    rd(`SWKC_IDX_IFL);
    chk({d[3:2], 2'b00}, 4'hC);
    tally_and_finish();
  end
endmodule
